/* File: logic/pts_consts.vh */
// Constants for the process timer and supervision block.
`ifndef PTS_CONSTS_VH
`define PTS_CONSTS_VH
// Register byte offsets on the APB.
`define PTS_OFF_CTRL 12'h000
`define PTS_OFF_TIMER 12'h004
`define PTS_OFF_PROC 12'h008
`define PTS_OFF_STATUS 12'h00C
`define PTS_OFF_COUNT 12'h010
// Control register fields.
`define PTS_C_RUN 0
`define PTS_C_BLK0 1
`define PTS_C_BLK1 2
`define PTS_C_SB0 3
`define PTS_C_SB1 4
`define PTS_C_PID 5
`define PTS_C_ENDRUN 6
`define PTS_C_ONEND 7
`define PTS_C_BASE 8
`define PTS_C_DOWN 9
`define PTS_C_TRIG_LO 10
`define PTS_C_LBD_LO 16
`define PTS_C_PCT_LO 24
`define PTS_CTRL_RESET 32'h0000_0000
`define PTS_CTRL_MASK 32'h7FFF_FFFF
// Trigger selections.
`define PTS_TRIG_OFF 2'h0
`define PTS_TRIG_SP 2'h1
`define PTS_TRIG_KEY 2'h2
`define PTS_TRIG_RUN 2'h3
// Timing: one-second tick and key press lengths, 200 MHz clock.
`define PTS_CLK_HZ 200000000
`define PTS_SHORT_MS 1000
`define PTS_LONG_MS 3000
`define PTS_FAST_DIV 8'h08
`define PTS_SLOW_DIV 8'h20
`define PTS_PCT_MAX 7'h64
`endif

/* File: logic/pts_supervisor.v */
// Supervisory logic: alarm blocking, run gate, safe output, loop break, timers.
`timescale 1ns/100ps
`default_nettype none
`include "pts_consts.vh"
module pts_supervisor #(
  parameter [27:0] TICK_CYCLES = 28'd200000000,
  parameter [7:0] SHORT_TICKS = 8'd1,
  parameter [7:0] LONG_TICKS = 8'd3
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [1:0] alarm_cond_in,
  input wire sensor_fault_in,
  input wire pv_at_sp_in,
  input wire pv_react_in,
  input wire key_in,
  input wire [6:0] ctrl_pct_in,
  output reg [6:0] ctrl_pct_out,
  output reg [1:0] alarm_out,
  output reg loop_break_out,
  output reg primary_timer_out,
  output reg secondary_timer_out,
  output reg run_lamp,
  output reg primary_timer_lamp,
  output reg secondary_timer_lamp
);
  // Timer states.
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_T1 = 3'd1;
  localparam [2:0] ST_T2 = 3'd2;
  localparam [2:0] ST_DONE = 3'd3;
  // Configuration and status registers.
  reg [31:0] ctrl_reg; // Mode, enables, loop interval, safe percentage.
  reg [31:0] timer_reg; // Low half primary, high half secondary interval.
  reg run_reg; // Effective run enable; also cleared by end of sequence.
  reg [31:0] rd_next; // Read data mux.
  // Synchronisers for the alarm, fault, setpoint, reaction and key pins: two flops before any logic reads them.
  reg [5:0] sync1_reg;
  reg [5:0] sync2_reg;
  wire [1:0] alarm_s = sync2_reg[1:0];
  wire fault_s = sync2_reg[2];
  wire at_sp_s = sync2_reg[3];
  wire react_s = sync2_reg[4];
  wire key_s = sync2_reg[5];
  // Field decode.
  wire [1:0] trig = ctrl_reg[`PTS_C_TRIG_LO+1:`PTS_C_TRIG_LO];
  wire [7:0] lbd_min = ctrl_reg[`PTS_C_LBD_LO+7:`PTS_C_LBD_LO];
  wire [6:0] safe_pct = ctrl_reg[`PTS_C_PCT_LO+6:`PTS_C_PCT_LO];
  wire [1:0] blk_en = {ctrl_reg[`PTS_C_BLK1], ctrl_reg[`PTS_C_BLK0]};
  wire [1:0] sb_fn = {ctrl_reg[`PTS_C_SB1], ctrl_reg[`PTS_C_SB0]};
  // Bus strobes.
  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & penable & ~pwrite;

  // Returns whether an address is one of the mapped words.
  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `PTS_OFF_CTRL) || (a == `PTS_OFF_TIMER) ||
               (a == `PTS_OFF_PROC) || (a == `PTS_OFF_STATUS) ||
               (a == `PTS_OFF_COUNT);
    end
  endfunction

  // Clamps a safe percentage to what the control mode accepts.
  function [6:0] legal_pct;
    input [6:0] v;
    input pid;
    begin
      if (pid) begin
        legal_pct = (v > `PTS_PCT_MAX) ? `PTS_PCT_MAX : v;
      end else begin
        legal_pct = (v >= 7'h32) ? `PTS_PCT_MAX : 7'h00;
      end
    end
  endfunction

  // Input synchroniser chain.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
    end else begin
      sync1_reg <= {key_in, pv_react_in, pv_at_sp_in, sensor_fault_in,
                    alarm_cond_in};
      sync2_reg <= sync1_reg;
    end
  end

  // Prescaler: one-second tick and lamp flash enables.
  reg [27:0] pre_reg;
  reg tick_reg;
  reg [7:0] flash_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 28'h0000000;
      tick_reg <= 1'b0;
      flash_reg <= 8'h00;
    end else begin
      tick_reg <= 1'b0;
      if (pre_reg == TICK_CYCLES - 28'd1) begin
        pre_reg <= 28'h0000000;
        tick_reg <= 1'b1;
      end else begin
        pre_reg <= pre_reg + 28'd1;
      end
      if (pre_reg[19:0] == 20'h00000) begin
        flash_reg <= flash_reg + 8'h01;
      end
    end
  end
  wire slow_blink = flash_reg[5];
  wire fast_blink = flash_reg[3];

  // APB register writes; run bit also cleared by end of timer sequence.
  reg seq_end; // Pulse from the timer when the full sequence completes or a long key press ends it.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `PTS_CTRL_RESET;
      timer_reg <= 32'h00000000;
      run_reg <= 1'b0;
    end else begin
      if (wr_en && paddr == `PTS_OFF_CTRL) begin
        ctrl_reg <= pwdata & `PTS_CTRL_MASK;
        run_reg <= pwdata[`PTS_C_RUN];
      end else if (seq_end && ctrl_reg[`PTS_C_ENDRUN]) begin
        run_reg <= 1'b0;
      end
      if (wr_en && paddr == `PTS_OFF_TIMER) begin
        timer_reg <= pwdata;
      end
    end
  end

  // Start-up alarm blocking per channel.
  reg [1:0] blocked_reg;
  reg first_reg;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_blk
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          blocked_reg[g] <= 1'b0;
        end else if (first_reg) begin
          // Record presence at start-up; enables apply at the output, so
          // software may set them after the boot sample has been taken.
          blocked_reg[g] <= alarm_s[g];
        end else if (blocked_reg[g] && !alarm_s[g]) begin
          blocked_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate
  // First-cycle marker, held until synchronisers have filled.
  reg [1:0] boot_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_reg <= 2'h0;
      first_reg <= 1'b0;
    end else begin
      if (boot_reg != 2'h3) begin
        boot_reg <= boot_reg + 2'h1;
      end
      first_reg <= (boot_reg == 2'h2);
    end
  end

  // Loop break: count minutes without PV reaction.
  reg [5:0] lb_sec_reg;
  reg [7:0] lb_min_reg;
  reg lb_event_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lb_sec_reg <= 6'h00;
      lb_min_reg <= 8'h00;
      lb_event_reg <= 1'b0;
    end else if (lbd_min == 8'h00 || !run_reg || react_s) begin
      lb_sec_reg <= 6'h00;
      lb_min_reg <= 8'h00;
      lb_event_reg <= 1'b0;
    end else if (tick_reg) begin
      if (lb_sec_reg == 6'd59) begin
        lb_sec_reg <= 6'h00;
        if (lb_min_reg + 8'h01 >= lbd_min) begin
          lb_event_reg <= 1'b1;
        end else begin
          lb_min_reg <= lb_min_reg + 8'h01;
        end
      end else begin
        lb_sec_reg <= lb_sec_reg + 6'h01;
      end
    end
  end

  // Key press length measured in seconds while held.
  reg [7:0] hold_reg;
  reg key_d_reg;
  reg short_reg;
  reg long_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg <= 8'h00;
      key_d_reg <= 1'b0;
      short_reg <= 1'b0;
      long_reg <= 1'b0;
    end else begin
      key_d_reg <= key_s;
      short_reg <= 1'b0;
      long_reg <= 1'b0;
      if (key_s) begin
        if (tick_reg && hold_reg != 8'hFF) begin
          hold_reg <= hold_reg + 8'h01;
        end
        if (tick_reg && hold_reg + 8'h01 == LONG_TICKS) begin
          long_reg <= 1'b1;
        end
      end else begin
        hold_reg <= 8'h00;
        if (key_d_reg && hold_reg >= SHORT_TICKS - 8'h01 &&
            hold_reg < LONG_TICKS) begin
          short_reg <= 1'b1;
        end
      end
    end
  end

  // Two-stage timer sequencer with sub-unit counter.
  reg [2:0] st_reg;
  reg paused_reg;
  reg [5:0] sub_reg;
  reg [15:0] cnt_reg;
  reg run_d_reg;
  reg at_sp_d_reg;
  wire [15:0] t1_len = timer_reg[15:0];
  wire [15:0] t2_len = timer_reg[31:16];
  wire key_ok = (trig == `PTS_TRIG_KEY) && run_reg;
  wire start = (st_reg == ST_IDLE || st_reg == ST_DONE) && (
    (trig == `PTS_TRIG_SP && at_sp_s && !at_sp_d_reg) ||
    (key_ok && short_reg) ||
    (trig == `PTS_TRIG_RUN && run_reg && !run_d_reg));
  wire down = ctrl_reg[`PTS_C_DOWN];
  // Sub-unit rollover: 60 s per minute in HH:MM, 1 s in MM:SS.
  wire unit_step = tick_reg && (!ctrl_reg[`PTS_C_BASE] ||
                   sub_reg == 6'd59);
  wire [15:0] cur_len = (st_reg == ST_T1) ? t1_len : t2_len;
  wire expire = down ? (cnt_reg <= 16'h0001) :
                (cnt_reg + 16'h0001 >= cur_len);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= ST_IDLE;
      paused_reg <= 1'b0;
      sub_reg <= 6'h00;
      cnt_reg <= 16'h0000;
      run_d_reg <= 1'b0;
      at_sp_d_reg <= 1'b0;
      seq_end <= 1'b0;
    end else begin
      run_d_reg <= run_reg;
      at_sp_d_reg <= at_sp_s;
      seq_end <= 1'b0;
      if (trig == `PTS_TRIG_OFF) begin
        st_reg <= ST_IDLE;
        paused_reg <= 1'b0;
      end else if (start) begin
        st_reg <= ST_T1;
        paused_reg <= 1'b0;
        sub_reg <= 6'h00;
        cnt_reg <= down ? t1_len : 16'h0000;
      end else if (st_reg == ST_T1 || st_reg == ST_T2) begin
        if (key_ok && long_reg) begin
          st_reg <= ST_DONE;
          paused_reg <= 1'b0;
          seq_end <= 1'b1;
        end else if (key_ok && short_reg) begin
          paused_reg <= ~paused_reg;
        end else if (!paused_reg && tick_reg) begin
          sub_reg <= (sub_reg == 6'd59) ? 6'h00 : sub_reg + 6'h01;
          if (unit_step) begin
            if (expire && st_reg == ST_T1) begin
              st_reg <= ST_T2;
              sub_reg <= 6'h00;
              cnt_reg <= down ? t2_len : 16'h0000;
            end else if (expire) begin
              st_reg <= ST_DONE;
              seq_end <= 1'b1;
              cnt_reg <= down ? 16'h0000 : cur_len;
            end else begin
              cnt_reg <= down ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001;
            end
          end
        end
      end
    end
  end

  // Output stage: every output from a flop; percentage, alarm and loop-break outputs gated by run enable.
  wire t1_run = (st_reg == ST_T1);
  wire t2_run = (st_reg == ST_T2);
  wire t1_after = (st_reg == ST_T2) || (st_reg == ST_DONE);
  wire on_end = ctrl_reg[`PTS_C_ONEND];
  wire [6:0] safe = legal_pct(safe_pct, ctrl_reg[`PTS_C_PID]);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_pct_out <= 7'h00;
      alarm_out <= 2'h0;
      loop_break_out <= 1'b0;
      primary_timer_out <= 1'b0;
      secondary_timer_out <= 1'b0;
      run_lamp <= 1'b0;
      primary_timer_lamp <= 1'b0;
      secondary_timer_lamp <= 1'b0;
    end else begin
      run_lamp <= run_reg;
      if (!run_reg) begin
        ctrl_pct_out <= 7'h00;
        alarm_out <= 2'h0;
        loop_break_out <= 1'b0;
      end else begin
        ctrl_pct_out <= fault_s ? safe : ctrl_pct_in;
        alarm_out <= alarm_s & ~(blocked_reg & blk_en & ~sb_fn);
        loop_break_out <= lb_event_reg;
      end
      // Timer outputs run independently of the run gate.
      primary_timer_out <= on_end ? t1_after : t1_run;
      secondary_timer_out <= t2_run;
      if (t1_run) begin
        primary_timer_lamp <= paused_reg ? fast_blink : slow_blink;
      end else begin
        primary_timer_lamp <= on_end & t1_after;
      end
      if (t2_run) begin
        secondary_timer_lamp <= paused_reg ? fast_blink : slow_blink;
      end else begin
        secondary_timer_lamp <= 1'b0;
      end
    end
  end

  // Read mux.
  always @* begin
    case (paddr)
      `PTS_OFF_CTRL: rd_next = {ctrl_reg[31:1], run_reg};
      `PTS_OFF_TIMER: rd_next = timer_reg;
      `PTS_OFF_PROC: rd_next = {25'h0000000, safe};
      `PTS_OFF_STATUS: rd_next = {24'h000000, paused_reg, st_reg,
                                  lb_event_reg, blocked_reg, fault_s};
      `PTS_OFF_COUNT: rd_next = {16'h0000, cnt_reg};
      default: rd_next = 32'h00000000;
    endcase
  end

  // APB answer: no wait state, so pready rises in the first access cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped(paddr);
      if (rd_en | (psel & ~pwrite)) begin
        prdata <= rd_next;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/pts_supervisor_monitor.sv */
// Checker for the supervision block, bound to its top module ports.
`timescale 1ns/100ps
`default_nettype none
module pts_supervisor_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] alarm_cond_in,
  input wire logic sensor_fault_in,
  input wire logic pv_at_sp_in,
  input wire logic pv_react_in,
  input wire logic key_in,
  input wire logic [6:0] ctrl_pct_in,
  input wire logic [6:0] ctrl_pct_out,
  input wire logic [1:0] alarm_out,
  input wire logic loop_break_out,
  input wire logic primary_timer_out,
  input wire logic secondary_timer_out,
  input wire logic run_lamp,
  input wire logic primary_timer_lamp,
  input wire logic secondary_timer_lamp
);
  // One clock domain, so clock and reset are given once.
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // The slave answers a setup cycle with no wait state.
  property p_apb_wait; psel && !penable |=> pready; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("pready late");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("stray pslverr");
  property p_err_zero;
    pready && pslverr && !pwrite |-> prdata == 32'h0000_0000;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("bad read data");
  // Three idle-lamp cycles leave room for the output register to follow.
  property p_run_off;
    !run_lamp [*3] |-> alarm_out == 2'h0 && ctrl_pct_out == 7'h00;
  endproperty
  a_run_off: assert property (p_run_off) else $error("outputs live");
  property p_run_pass;
    (run_lamp && !sensor_fault_in && $stable(ctrl_pct_in)) [*4]
      |-> ctrl_pct_out == ctrl_pct_in;
  endproperty
  a_run_pass: assert property (p_run_pass) else $error("pct lost");
  property p_run_lamp;
    psel && penable && pready && pwrite && paddr == 12'h000 && pwdata[0]
      |-> ##[1:3] run_lamp;
  endproperty
  a_run_lamp: assert property (p_run_lamp) else $error("lamp dark");
  property p_sec_lamp; secondary_timer_lamp |-> secondary_timer_out;
  endproperty
  a_sec_lamp: assert property (p_sec_lamp) else $error("lamp idle");
  c_err: cover property (pslverr);
  c_lbd: cover property (loop_break_out);
  c_sec: cover property (secondary_timer_lamp);
endmodule
`default_nettype wire

/* File: testbench/pts_panel_model.sv */
// Front-panel key model: an operator holding the key for a given time.
`timescale 1ns/100ps
`default_nettype none
module pts_panel_model (
  input wire logic pclk,
  output var logic key_in
);
  initial key_in = 1'b0;
  // Hold for n cycles, then stay off long enough to read as a new press.
  task automatic press(input int n);
    @(posedge pclk);
    key_in <= 1'b1;
    repeat (n) @(posedge pclk);
    key_in <= 1'b0;
    repeat (30) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

/* File: testbench/pts_supervisor_bench.sv */
// Self-checking bench for the supervision block.
`timescale 1ns/100ps
`default_nettype none
`include "pts_consts.vh"
module pts_supervisor_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, sensor_fault_in = 1'b0, pv_at_sp_in = 1'b0;
  logic pv_react_in = 1'b0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  // Alarms stand from power-up so that start-up blocking has work to do.
  logic [1:0] alarm_cond_in = 2'h3, alarm_out;
  logic [6:0] ctrl_pct_in = 7'h2A, ctrl_pct_out;
  logic loop_break_out, primary_timer_out, secondary_timer_out, run_lamp;
  logic primary_timer_lamp, secondary_timer_lamp;
  wire key_in;
  int n_mismatch = 0, cmp_count = 0;
  always #2.5 pclk = ~pclk;
  // The tick is cut to 20 cycles so timer runs stay short.
  pts_supervisor #(.TICK_CYCLES(28'd20)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .alarm_cond_in(alarm_cond_in),
    .sensor_fault_in(sensor_fault_in), .pv_at_sp_in(pv_at_sp_in),
    .pv_react_in(pv_react_in), .key_in(key_in), .ctrl_pct_in(ctrl_pct_in),
    .ctrl_pct_out(ctrl_pct_out), .alarm_out(alarm_out),
    .loop_break_out(loop_break_out), .primary_timer_out(primary_timer_out),
    .secondary_timer_out(secondary_timer_out), .run_lamp(run_lamp),
    .primary_timer_lamp(primary_timer_lamp),
    .secondary_timer_lamp(secondary_timer_lamp));
  pts_panel_model panel (.pclk(pclk), .key_in(key_in));
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; waits for pready under a bound, then releases.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk("pready", 32'h1, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Poll the sequence state until it matches or the limit runs out.
  task automatic st_wait(input logic [2:0] s, input int lim);
    int i;
    i = 0;
    do begin
      apb(1'b0, `PTS_OFF_STATUS, 32'h0);
      i++;
    end while (rd[6:4] !== s && i < lim);
    chk("state", {29'h0, s}, {29'h0, rd[6:4]});
  endtask
  task automatic t_regs;
    apb(1'b0, `PTS_OFF_CTRL, 32'h0);
    chk("ctrl reset", `PTS_CTRL_RESET, rd);
    wr(`PTS_OFF_CTRL, 32'hFFFF_FFFE);
    apb(1'b0, `PTS_OFF_CTRL, 32'h0);
    chk("ctrl mask", 32'h7FFF_FFFE, rd);
    wr(`PTS_OFF_CTRL, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
  endtask
  task automatic t_run;
    alarm_cond_in <= 2'h3;
    repeat (6) @(posedge pclk);
    chk("alarm off", 32'h0, {30'h0, alarm_out});
    chk("pct off", 32'h0, {25'h0, ctrl_pct_out});
    chk("lamp off", 32'h0, {31'h0, run_lamp});
    wr(`PTS_OFF_CTRL, 32'h0000_0001);
    repeat (6) @(posedge pclk);
    chk("alarm on", 32'h3, {30'h0, alarm_out});
    chk("pct on", 32'h2A, {25'h0, ctrl_pct_out});
    chk("lamp on", 32'h1, {31'h0, run_lamp});
    ctrl_pct_in <= 7'h51;
    repeat (3) @(posedge pclk);
    chk("pct follow", 32'h51, {25'h0, ctrl_pct_out});
    ctrl_pct_in <= 7'h2A;
    // Block both channels; channel one is of the sensor-break kind.
    wr(`PTS_OFF_CTRL, 32'h0000_0017);
    repeat (6) @(posedge pclk);
    chk("alarm blocked", 32'h2, {30'h0, alarm_out});
    alarm_cond_in <= 2'h0;
    repeat (6) @(posedge pclk);
    alarm_cond_in <= 2'h3;
    repeat (6) @(posedge pclk);
    chk("alarm rearmed", 32'h3, {30'h0, alarm_out});
    alarm_cond_in <= 2'h0;
  endtask
  // PID takes any percentage; on/off rounds to 0 or 100.
  task automatic t_safe;
    logic [31:0] cw [3];
    logic [6:0] ex [3];
    cw = '{32'h2500_0021, 32'h2500_0001, 32'h3C00_0001};
    ex = '{7'h25, 7'h00, `PTS_PCT_MAX};
    for (int i = 0; i < 3; i++) begin
      wr(`PTS_OFF_CTRL, cw[i]);
      sensor_fault_in <= 1'b1;
      repeat (6) @(posedge pclk);
      chk("safe pct", {25'h0, ex[i]}, {25'h0, ctrl_pct_out});
      apb(1'b0, `PTS_OFF_PROC, 32'h0);
      chk("safe reg", {25'h0, ex[i]}, rd);
      sensor_fault_in <= 1'b0;
      repeat (6) @(posedge pclk);
      chk("pct back", 32'h2A, {25'h0, ctrl_pct_out});
    end
  endtask
  task automatic t_lbd;
    wr(`PTS_OFF_CTRL, 32'h0001_0001);
    repeat (1500) @(posedge pclk);
    chk("lbd out", 32'h1, {31'h0, loop_break_out});
    apb(1'b0, `PTS_OFF_STATUS, 32'h0);
    chk("lbd flag", 32'h1, {31'h0, rd[3]});
    wr(`PTS_OFF_CTRL, 32'h0000_0001);
    pv_react_in <= 1'b1;
    repeat (3) @(posedge pclk);
    pv_react_in <= 1'b0;
    repeat (1500) @(posedge pclk);
    chk("lbd off", 32'h0, {31'h0, loop_break_out});
  endtask
  task automatic t_tkey;
    wr(`PTS_OFF_TIMER, {16'd2, 16'd200});
    wr(`PTS_OFF_CTRL, 32'h0000_0880);
    panel.press(30);
    st_wait(3'h0, 1);
    wr(`PTS_OFF_CTRL, 32'h0000_0881);
    panel.press(30);
    st_wait(3'h1, 1);
    chk("t1 out", 32'h0, {31'h0, primary_timer_out});
    panel.press(30);
    apb(1'b0, `PTS_OFF_STATUS, 32'h0);
    chk("paused", 32'h1, {31'h0, rd[7]});
    panel.press(30);
    apb(1'b0, `PTS_OFF_STATUS, 32'h0);
    chk("resumed", 32'h0, {31'h0, rd[7]});
    panel.press(70);
    apb(1'b0, `PTS_OFF_STATUS, 32'h0);
    chk("aborted", 32'h0, {31'h0, rd[6:4] == 3'h1 || rd[6:4] == 3'h2});
  endtask
  task automatic t_tsp;
    wr(`PTS_OFF_CTRL, 32'h0000_0001);
    pv_at_sp_in <= 1'b1;
    repeat (60) @(posedge pclk);
    st_wait(3'h0, 1);
    // The start is taken on a fresh arrival at setpoint, so drop it first.
    pv_at_sp_in <= 1'b0;
    wr(`PTS_OFF_CTRL, 32'h0000_0401);
    pv_at_sp_in <= 1'b1;
    st_wait(3'h1, 3);
    pv_at_sp_in <= 1'b0;
    wr(`PTS_OFF_CTRL, 32'h0);
  endtask
  task automatic t_trun;
    wr(`PTS_OFF_TIMER, {16'd2, 16'd2});
    wr(`PTS_OFF_CTRL, 32'h0000_0E40);
    repeat (60) @(posedge pclk);
    st_wait(3'h0, 1);
    wr(`PTS_OFF_CTRL, 32'h0000_0E41);
    st_wait(3'h1, 3);
    chk("t1 on", 32'h1, {31'h0, primary_timer_out});
    st_wait(3'h2, 40);
    chk("t1 end", 32'h0, {31'h0, primary_timer_out});
    chk("t1 lamp", 32'h0, {31'h0, primary_timer_lamp});
    st_wait(3'h3, 40);
    // Down counting, so the count rests at zero once the sequence is done.
    apb(1'b0, `PTS_OFF_COUNT, 32'h0);
    chk("count end", 32'h0, rd);
    chk("t2 lamp", 32'h0, {31'h0, secondary_timer_lamp});
    repeat (4) @(posedge pclk);
    chk("end run", 32'h0, {31'h0, run_lamp});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence after ten reset cycles.
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_regs;
    t_run;
    t_safe;
    t_lbd;
    t_tkey;
    t_tsp;
    t_trun;
    tally_and_finish;
  end
  // The tests need well under 20000 cycles; this cuts a hang short.
  initial begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    tally_and_finish;
  end
endmodule
bind pts_supervisor pts_supervisor_monitor u_mon (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .alarm_cond_in(alarm_cond_in),
  .sensor_fault_in(sensor_fault_in), .pv_at_sp_in(pv_at_sp_in),
  .pv_react_in(pv_react_in), .key_in(key_in), .ctrl_pct_in(ctrl_pct_in),
  .ctrl_pct_out(ctrl_pct_out), .alarm_out(alarm_out),
  .loop_break_out(loop_break_out), .primary_timer_out(primary_timer_out),
  .secondary_timer_out(secondary_timer_out), .run_lamp(run_lamp),
  .primary_timer_lamp(primary_timer_lamp),
  .secondary_timer_lamp(secondary_timer_lamp));
`default_nettype wire
